// File: dv/sdram_pin_command_interface_tb_top.sv
// self-checking bench: controller and device joined across the pin bundle
`timescale 1ns/1ns
module sdram_pin_command_interface_tb_top;
    logic        sys_clk, rst_n, req_valid, req_ready, req_cke, req_clk_stop, wr_drive, rd_valid;
    logic [3:0]  req_cmd, wr_mask;
    logic [2:0]  req_bank, power_state;
    logic [11:0] req_addr, mode_reg;
    logic [31:0] wr_data, rd_data, wr_word;
    logic [7:0]  bank_open;
    logic        wr_word_valid, wr_word_ready;
    int          n_mismatch, checked, n_rd, n_wr;
    always #25 sys_clk = ~sys_clk;
    spci_if pins_if ();
    spci_ctl spci_ctl_i (.sys_clk, .rst_n, .pins(pins_if), .req_valid, .req_ready, .req_cmd, .req_bank, .req_addr,
        .req_cke, .req_clk_stop, .wr_data, .wr_mask, .wr_drive, .rd_data, .rd_valid);
    spci_dev #(.DEPTH(16)) spci_dev_i (.sys_clk, .rst_n, .pins(pins_if), .power_state, .mode_reg, .bank_open,
        .wr_word_valid, .wr_word_ready, .wr_word);
    spci_properties spci_properties_i (.sys_clk, .rst_n, .ck(pins_if.ck), .ck_n(pins_if.ck_n), .cke(pins_if.cke),
        .cs_n(pins_if.cs_n), .ras_n(pins_if.ras_n), .cas_n(pins_if.cas_n), .we_n(pins_if.we_n),
        .bank_select(pins_if.bank_select), .address_in(pins_if.address_in), .write_strobe(pins_if.write_strobe),
        .read_strobe(pins_if.read_strobe), .dq_ctl_o(pins_if.dq_ctl_o), .dq_ctl_oe(pins_if.dq_ctl_oe),
        .dq_dev_o(pins_if.dq_dev_o), .dq_dev_oe(pins_if.dq_dev_oe));
    // count beats before the edge that takes them; lane 1 is masked on writes
    always @(negedge sys_clk) begin
        if (rd_valid === 1'b1) begin
            n_rd++;
            chk(rd_data & 32'hFFFF00FF, 32'hA5C3007F);
        end
        if (wr_word_valid === 1'b1 && wr_word_ready === 1'b1) begin
            n_wr++;
            chk(wr_word & 32'hFFFF00FF, 32'hA5C3007F);
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    // one command: hold until taken, then let the device decode it
    task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [11:0] a, input logic k);
        int i;
        {req_cmd, req_bank, req_addr, req_cke, req_valid} = {c, b, a, k, 1'b1};
        for (i = 0; i < 40 && req_ready !== 1'b1; i++) @(posedge sys_clk) #1;
        if (i == 40) begin
            n_mismatch++;
            close_out();
        end
        @(posedge sys_clk) #1;
        req_valid = 1'b0;
        repeat (16) @(posedge sys_clk);
        #1;
    endtask : cmd
    task automatic mode_and_banks;
        cmd(4'h0, 3'h0, 12'hA50, 1'b1);
        chk(32'(mode_reg), 32'hA50);
        cmd(4'h3, 3'h3, 12'hFFF, 1'b1);
        cmd(4'h3, 3'h5, 12'h000, 1'b1);
        chk(32'(bank_open), 32'h28);
        cmd(4'hB, 3'h0, 12'h000, 1'b1);
        chk(32'(bank_open), 32'h28);
        cmd(4'h2, 3'h3, 12'h000, 1'b1);
        chk(32'(bank_open), 32'h20);
        cmd(4'h2, 3'h0, 12'h100, 1'b1);
        chk(32'(bank_open), 32'h00);
    endtask : mode_and_banks
    // write with the receiver stalled, then read back, for both burst lengths
    task automatic burst_pair;
        int b;
        for (b = 0; b < 2; b++) begin
            cmd(4'h0, 3'h0, 12'(b), 1'b1);
            cmd(4'h3, 3'h2, 12'h7FF, 1'b1);
            {n_wr, n_rd, wr_word_ready, wr_drive} = {32'h0, 32'h0, 1'b0, 1'b1};
            cmd(4'h4, 3'h2, 12'h100, 1'b1);
            repeat (80) @(posedge sys_clk);
            #1 wr_word_ready = 1'b1;
            repeat (80) @(posedge sys_clk);
            #1 wr_drive = 1'b0;
            chk(32'(bank_open), 32'h0);
            chk(32'(n_wr), 32'(b ? spci_pkg::BL8 : spci_pkg::BL4));
            cmd(4'h3, 3'h2, 12'h7FF, 1'b1);
            cmd(4'h5, 3'h2, 12'h100, 1'b1);
            repeat (80) @(posedge sys_clk);
            #1 chk(32'(n_rd), 32'(b ? spci_pkg::BL8 : spci_pkg::BL4));
            chk(32'(bank_open), 32'h0);
        end
    endtask : burst_pair
    task automatic power_modes;
        cmd(4'h3, 3'h1, 12'h001, 1'b1);
        cmd(4'h7, 3'h0, 12'h000, 1'b0);
        chk(32'(power_state), 32'h2);
        cmd(4'h3, 3'h6, 12'h000, 1'b0);
        chk(32'(bank_open), 32'h02);
        cmd(4'h7, 3'h0, 12'h000, 1'b1);
        chk(32'(power_state), 32'h0);
        cmd(4'h2, 3'h0, 12'h100, 1'b1);
        cmd(4'h7, 3'h0, 12'h000, 1'b0);
        chk(32'(power_state), 32'h1);
        cmd(4'h7, 3'h0, 12'h000, 1'b1);
        req_clk_stop = 1'b1;
        cmd(4'h1, 3'h0, 12'h000, 1'b0);
        chk(32'(power_state), 32'h3);
        req_clk_stop = 1'b0;
        repeat (8) @(posedge sys_clk);
        #1;
        cmd(4'h7, 3'h0, 12'h000, 1'b1);
        chk(32'(power_state), 32'h0);
    endtask : power_modes
    initial begin
        {sys_clk, rst_n, req_valid, req_cke, req_clk_stop, wr_drive, wr_word_ready} = 7'h00;
        {req_cmd, req_bank, req_addr, wr_data, wr_mask} = {4'h7, 3'h0, 12'h000, 32'hA5C3_1E7F, 4'h2};
        {n_mismatch, checked, n_rd, n_wr} = '0;
        repeat (5) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        // first link clock rise still sees cke low from reset; wake the device
        cmd(4'h7, 3'h0, 12'h000, 1'b1);
        chk(32'(power_state), 32'h0);
        mode_and_banks();
        burst_pair();
        power_modes();
        close_out();
    end
endmodule : sdram_pin_command_interface_tb_top

// File: dv/spci_properties.sv
// concurrent checks on the pin bundle between controller and device
`timescale 1ns/1ns
module spci_properties (
    input wire logic                         sys_clk,      // system clock
    input wire logic                         rst_n,        // sync reset, low active
    input wire logic                         ck,           // link clock true
    input wire logic                         ck_n,         // link clock complement
    input wire logic                         cke,          // clock enable
    input wire logic                         cs_n,         // chip select
    input wire logic                         ras_n,        // row strobe
    input wire logic                         cas_n,        // column strobe
    input wire logic                         we_n,         // write enable
    input wire logic [spci_pkg::BANK_W-1:0]  bank_select,  // bank select
    input wire logic [spci_pkg::ADDR_W-1:0]  address_in,   // address
    input wire logic [spci_pkg::LANES-1:0]   write_strobe, // write strobes
    input wire logic [spci_pkg::LANES-1:0]   read_strobe,  // read strobes
    input wire logic [spci_pkg::DATA_W-1:0]  dq_ctl_o,     // controller data
    input wire logic                         dq_ctl_oe,    // controller drives
    input wire logic [spci_pkg::DATA_W-1:0]  dq_dev_o,     // device data
    input wire logic                         dq_dev_oe     // device drives
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // =====================================================================
    // helper: cycles since the link clock last moved
    logic [3:0] ck_still;                                  // saturating count
    always_ff @(posedge sys_clk) begin
        if (!rst_n) ck_still <= 4'h0;
        else if ($changed(ck)) ck_still <= 4'h0;
        else if (ck_still != 4'hF) ck_still <= ck_still + 4'h1;
    end
    // =====================================================================
    // assertions
    ck_pair_a: assert property (ck_n == !ck) else $error("clock pair not complementary");
    ck_run_a: assert property (ck_still > 4'h4 |-> !cke)
        else $error("link clock stopped out of self-refresh");
    cmd_hold_a: assert property ($rose(ck) |-> $stable({cs_n, ras_n, cas_n, we_n, bank_select, address_in})[*4])
        else $error("command pins moved around clock rise");
    ctl_cke_a: assert property (dq_ctl_oe |-> cke) else $error("write data with clock enable low");
    dev_cke_a: assert property (dq_dev_oe |-> cke) else $error("read data driven while powered down");
    bus_owner_a: assert property (!(dq_ctl_oe && dq_dev_oe)) else $error("both ends drive the data bus");
    rstrobe_lane_a: assert property (dq_dev_oe |-> read_strobe inside {4'h0, 4'hF})
        else $error("read lanes split");
    wstrobe_eye_a: assert property (dq_ctl_oe && $changed(write_strobe) |-> $stable(dq_ctl_o))
        else $error("write strobe edge on a data change");
    rstrobe_edge_a: assert property (dq_dev_oe && $past(dq_dev_oe) && $changed(dq_dev_o) |-> $changed(read_strobe))
        else $error("read data moved without its strobe");
    // covers for the main traffic
    cover property ($rose(dq_dev_oe));
    cover property ($rose(dq_ctl_oe));
    cover property ($fell(cke));
endmodule : spci_properties

// File: rtl/spci_ctl.sv
// controller end: makes the link clock, issues commands, moves data beats
`timescale 1ns/1ns
module spci_ctl (
    input  wire logic                           sys_clk,    // system clock
    input  wire logic                           rst_n,      // sync reset, low active
    spci_if.ctl                                 pins,       // memory pins
    input  wire logic                           req_valid,  // command request
    output logic                                req_ready,  // command taken
    input  wire logic [3:0]                     req_cmd,    // spci_cmd_e code
    input  wire logic [spci_pkg::BANK_W-1:0]    req_bank,   // bank
    input  wire logic [spci_pkg::ADDR_W-1:0]    req_addr,   // address / op-code
    input  wire logic                           req_cke,    // wanted clock enable
    input  wire logic                           req_clk_stop, // stop ck (self-refresh only)
    input  wire logic [spci_pkg::DATA_W-1:0]    wr_data,    // write beat
    input  wire logic [spci_pkg::LANES-1:0]     wr_mask,    // write beat mask
    input  wire logic                           wr_drive,   // drive a write beat
    output logic [spci_pkg::DATA_W-1:0]         rd_data,    // captured read beat
    output logic                                rd_valid    // read beat pulse
);
    // =====================================================================
    // link clock divider
    logic [2:0] div_cnt;                          // half-period counter
    logic       ck_q;                             // generated clock level
    logic       half_tick;                        // one-cycle enable per half period
    logic       in_sr;                            // self-refresh, clock may stop
    assign half_tick = (div_cnt == 3'(spci_pkg::CK_HALF - 1));
    // run divider; in self-refresh the clock parks high, after the rise that carried the entry
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            div_cnt <= 3'h0;
            ck_q    <= 1'b0;
        end else if (half_tick) begin
            div_cnt <= 3'h0;
            if (!(in_sr && req_clk_stop && ck_q)) begin
                ck_q <= ~ck_q;
            end
        end else begin
            div_cnt <= div_cnt + 3'h1;
        end
    end
    // =====================================================================
    // command issue: change pins as ck falls, device samples on rise
    logic issue;                                  // launch point
    assign issue     = half_tick && ck_q;
    assign req_ready = issue;
    // drive command pins
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= spci_pkg::SPCI_CMD_DESL;
            pins.bank_select <= '0;
            pins.address_in  <= '0;
            pins.cke         <= 1'b0;
            in_sr            <= 1'b0;
        end else if (issue) begin
            pins.cke <= req_cke;
            if (req_valid) begin
                {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= req_cmd;
                pins.bank_select <= req_bank;
                pins.address_in  <= req_addr;
                in_sr <= !req_cke && (req_cmd == spci_pkg::SPCI_CMD_REF);
            end else begin
                {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= spci_pkg::SPCI_CMD_NOP;
                if (req_cke) begin
                    in_sr <= 1'b0;
                end
            end
        end
    end
    assign pins.ck   = ck_q;
    assign pins.ck_n = ~ck_q;
    // =====================================================================
    // write data: change at each half edge, strobe toggles mid-eye
    logic [spci_pkg::LANES-1:0] wstb;             // write strobe level
    // launch data and mask at each half period; caller keeps cke high
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pins.dq_ctl_o   <= '0;
            pins.dq_ctl_oe  <= 1'b0;
            pins.write_mask <= '0;
        end else if (half_tick) begin
            pins.dq_ctl_o   <= wr_data;
            pins.dq_ctl_oe  <= wr_drive;
            pins.write_mask <= wr_mask;
        end
    end
    // strobe edge half way through the data eye
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wstb <= '0;
        end else if (pins.dq_ctl_oe && div_cnt == 3'(spci_pkg::CK_HALF / 2 - 1)) begin
            wstb <= ~wstb;
        end else if (!pins.dq_ctl_oe) begin
            wstb <= '0;
        end
    end
    assign pins.write_strobe = wstb;
    // =====================================================================
    // read capture: sample strobe pins through two flops, catch on each edge
    logic [spci_pkg::LANES-1:0] rs_s1, rs_s2, rs_s3; // strobe synchroniser
    logic [spci_pkg::DATA_W-1:0] rd_s1, rd_s2;    // data synchroniser
    // synchronise read strobe and bus
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rs_s1 <= '0;
            rs_s2 <= '0;
            rs_s3 <= '0;
            rd_s1 <= '0;
            rd_s2 <= '0;
        end else begin
            rs_s1 <= pins.read_strobe;
            rs_s2 <= rs_s1;
            rs_s3 <= rs_s2;
            rd_s1 <= pins.data_bus;
            rd_s2 <= rd_s1;
        end
    end
    // a lane 0 strobe edge marks a read beat
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rd_data  <= '0;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= (rs_s2[0] != rs_s3[0]);
            if (rs_s2[0] != rs_s3[0]) begin
                rd_data <= rd_s2;
            end
        end
    end
endmodule : spci_ctl

// File: rtl/spci_dev.sv
// device end: samples the link clock, decodes commands, moves data beats
`timescale 1ns/1ns
module spci_dev #(
    parameter int DEPTH = 16                      // words of backing store
) (
    input  wire logic                           sys_clk,    // system clock
    input  wire logic                           rst_n,      // sync reset, low active
    spci_if.dev                                 pins,       // memory pins
    output logic [2:0]                          power_state,// 0 up,1 ppd,2 apd,3 sr
    output logic [spci_pkg::ADDR_W-1:0]         mode_reg,   // loaded op-code
    output logic [spci_pkg::BANKS-1:0]          bank_open,  // open row per bank
    output logic                                wr_word_valid, // write word to user
    input  wire logic                           wr_word_ready, // user accepts word
    output logic [spci_pkg::DATA_W-1:0]         wr_word     // write word data
);
    // =====================================================================
    // pin synchronisers: two flops before any logic
    logic       ck_s1, ck_s2, ck_s3;              // link clock sync and history
    logic       cke_s1, cke_s2;                   // clock enable sync
    logic [3:0] cmd_s1, cmd_s2;                   // command pins
    logic [spci_pkg::BANK_W-1:0] ba_s1, ba_s2;    // bank pins
    logic [spci_pkg::ADDR_W-1:0] a_s1, a_s2;      // address pins
    logic [spci_pkg::LANES-1:0]  dm_s1, dm_s2;    // mask pins
    logic [spci_pkg::DATA_W-1:0] dq_s1, dq_s2;    // data pins
    // two-flop capture of all inputs except ck_n and write_strobe
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            {ck_s1, ck_s2, ck_s3, cke_s1, cke_s2} <= 5'h00;
            cmd_s1 <= 4'hF;
            cmd_s2 <= 4'hF;
            {ba_s1, ba_s2, a_s1, a_s2} <= '0;
            {dm_s1, dm_s2, dq_s1, dq_s2} <= '0;
        end else begin
            ck_s1  <= pins.ck;
            ck_s2  <= ck_s1;
            ck_s3  <= ck_s2;
            cke_s1 <= pins.cke;
            cke_s2 <= cke_s1;
            cmd_s1 <= {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
            cmd_s2 <= cmd_s1;
            ba_s1  <= pins.bank_select;
            ba_s2  <= ba_s1;
            a_s1   <= pins.address_in;
            a_s2   <= a_s1;
            dm_s1  <= pins.write_mask;
            dm_s2  <= dm_s1;
            dq_s1  <= pins.data_bus;
            dq_s2  <= dq_s1;
        end
    end
    logic rise, fall;                             // link clock edges
    assign rise = ck_s2 && !ck_s3;                // true rising, complement falling
    assign fall = !ck_s2 && ck_s3;
    // =====================================================================
    // power state
    typedef enum logic [1:0] {
        SPCI_UP  = 2'h0,                          // active
        SPCI_PPD = 2'h1,                          // precharge power-down
        SPCI_SR  = 2'h3,                          // self-refresh
        SPCI_APD = 2'h2                           // active power-down
    } spci_pwr_e;
    spci_pwr_e pwr;                               // current power state
    logic      awake;                             // inputs enabled
    logic      sel;                               // chip selected this edge
    spci_pkg::spci_cmd_e cmd;                     // decoded command
    assign cmd   = spci_pkg::spci_cmd_e'(cmd_s2);
    assign sel   = rise && !cmd_s2[3] && awake;
    assign awake = (pwr == SPCI_UP);
    // cke synchronous on ck edges; self-refresh exit on cke alone
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pwr <= SPCI_UP;
        end else begin
            unique case (pwr)
                SPCI_UP: if (rise && !cke_s2) begin
                    if (|bank_open) begin
                        pwr <= SPCI_APD;
                    end else if (!cmd_s2[3] && cmd == spci_pkg::SPCI_CMD_REF) begin
                        pwr <= SPCI_SR;
                    end else begin
                        pwr <= SPCI_PPD;
                    end
                end
                SPCI_PPD, SPCI_APD: if (rise && cke_s2) begin
                    pwr <= SPCI_UP;
                end
                SPCI_SR: if (cke_s2) begin                  // no clock needed
                    pwr <= SPCI_UP;
                end
            endcase
        end
    end
    assign power_state = {1'b0, pwr};
    // =====================================================================
    // bank, mode and access decode
    logic [3:0]  beats;                           // beats left in burst
    logic        wr_burst, rd_burst;              // burst direction
    logic [3:0]  col;                             // burst word pointer
    logic [spci_pkg::COL_W-1:0] col_base;         // column of the access
    logic        auto_pre;                        // precharge at burst end
    logic [spci_pkg::BANK_W-1:0] acc_bank;        // bank of the access
    logic [spci_pkg::ADDR_W-1:0] row [spci_pkg::BANKS]; // open row per bank
    logic [3:0]  bl;                              // burst length
    logic        buf_in_ready;                    // buffer has room
    assign bl = mode_reg[spci_pkg::BL_BIT] ? spci_pkg::BL8 : spci_pkg::BL4;
    // mode register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode_reg <= '0;
        end else if (sel && cmd == spci_pkg::SPCI_CMD_LMR) begin
            mode_reg <= a_s2;
        end
    end
    // open rows and precharge
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bank_open <= '0;
        end else if (sel && cmd == spci_pkg::SPCI_CMD_ACT) begin
            bank_open[ba_s2] <= 1'b1;
            row[ba_s2]       <= a_s2;
        end else if (sel && cmd == spci_pkg::SPCI_CMD_PRE) begin
            if (a_s2[spci_pkg::PRE_ALL_BIT]) begin
                bank_open <= '0;
            end else begin
                bank_open[ba_s2] <= 1'b0;
            end
        end else if (auto_pre && beats == 4'h1 && (rise || fall)) begin
            bank_open[acc_bank] <= 1'b0;
        end
    end
    // burst sequencer, one beat per link clock edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            {beats, col, col_base, auto_pre, acc_bank, wr_burst, rd_burst} <= '0;
        end else if (sel && (cmd == spci_pkg::SPCI_CMD_RD || cmd == spci_pkg::SPCI_CMD_WR)) begin
            beats    <= bl;
            col      <= 4'h0;
            col_base <= {a_s2[spci_pkg::COL_HI_BIT], a_s2[spci_pkg::COL_LO_TOP:0]};
            auto_pre <= a_s2[spci_pkg::AUTO_PRE_BIT];
            acc_bank <= ba_s2;
            wr_burst <= (cmd == spci_pkg::SPCI_CMD_WR);
            rd_burst <= (cmd == spci_pkg::SPCI_CMD_RD);
        end else if (beats != 4'h0 && (rise || fall) && !(wr_burst && !buf_in_ready)) begin
            beats <= beats - 4'h1;
            col   <= col + 4'h1;
            if (beats == 4'h1) begin
                {wr_burst, rd_burst} <= 2'b00;
            end
        end
    end
    // =====================================================================
    // storage with per-lane write masking
    logic [spci_pkg::DATA_W-1:0] mem [DEPTH];     // backing words
    localparam int IDX_W = $clog2(DEPTH);         // word index width
    logic [IDX_W-1:0]            widx;            // word index
    assign widx = IDX_W'(col_base + spci_pkg::COL_W'(col));
    // write beats land lane by lane unless masked
    always_ff @(posedge sys_clk) begin
        for (int l = 0; l < spci_pkg::LANES; l++) begin
            if (wr_burst && beats != 4'h0 && (rise || fall) && buf_in_ready && !dm_s2[l]) begin
                mem[widx][l*8 +: 8] <= dq_s2[l*8 +: 8];
            end
        end
    end
    // =====================================================================
    // two-entry buffer of write words toward the user side
    logic [spci_pkg::DATA_W-1:0] buf_q [2];       // entries
    logic [1:0]                  buf_cnt;         // fill level
    logic                        buf_rp, buf_wp;  // pointers
    logic                        push, pop;       // handshakes
    assign buf_in_ready  = (buf_cnt != 2'h2);
    assign push          = wr_burst && beats != 4'h0 && (rise || fall) && buf_in_ready;
    assign pop           = wr_word_valid && wr_word_ready;
    assign wr_word_valid = (buf_cnt != 2'h0);
    assign wr_word       = buf_q[buf_rp];
    // buffer pointers and fill level
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            {buf_cnt, buf_rp, buf_wp} <= '0;
        end else begin
            if (push) begin
                buf_q[buf_wp] <= dq_s2;
                buf_wp        <= ~buf_wp;
            end
            if (pop) begin
                buf_rp <= ~buf_rp;
            end
            buf_cnt <= buf_cnt + 2'(push) - 2'(pop);
        end
    end
    // =====================================================================
    // read launch: new beat and strobe toggle together on each edge
    logic [spci_pkg::LANES-1:0] rstb;             // read strobe level
    // drive bus and strobes during a read burst
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pins.dq_dev_o  <= '0;
            pins.dq_dev_oe <= 1'b0;
            rstb           <= '0;
        end else if (rd_burst && beats != 4'h0 && (rise || fall)) begin
            pins.dq_dev_o  <= mem[widx];
            pins.dq_dev_oe <= 1'b1;
            rstb           <= ~rstb;
        end else if (!rd_burst) begin
            pins.dq_dev_oe <= 1'b0;
        end
    end
    assign pins.read_strobe = rstb;
endmodule : spci_dev

// File: rtl/spci_if.sv
// pin bundle joining controller and memory device
`timescale 1ns/1ns
interface spci_if;
    logic                          ck;            // link clock true
    logic                          ck_n;          // link clock complement
    logic                          cke;           // clock enable
    logic                          cs_n;          // chip select, low active
    logic                          ras_n;         // row strobe
    logic                          cas_n;         // column strobe
    logic                          we_n;          // write enable
    logic [spci_pkg::BANK_W-1:0]   bank_select;   // bank select
    logic [spci_pkg::ADDR_W-1:0]   address_in;    // address
    logic [spci_pkg::LANES-1:0]    write_mask;    // per-lane write mask
    logic [spci_pkg::LANES-1:0]    write_strobe;  // per-lane write strobe
    logic [spci_pkg::LANES-1:0]    read_strobe;   // per-lane read strobe
    logic [spci_pkg::DATA_W-1:0]   dq_ctl_o;      // controller data out
    logic                          dq_ctl_oe;     // controller drives data
    logic [spci_pkg::DATA_W-1:0]   dq_dev_o;      // device data out
    logic                          dq_dev_oe;     // device drives data
    logic [spci_pkg::DATA_W-1:0]   data_bus;      // resolved shared bus
    // resolve the shared bus from the two enables
    assign data_bus = dq_ctl_oe ? dq_ctl_o : (dq_dev_oe ? dq_dev_o : '0);
    modport ctl (output ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, bank_select, address_in,
                 write_mask, write_strobe, dq_ctl_o, dq_ctl_oe, input read_strobe, data_bus);
    modport dev (input ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, bank_select, address_in,
                 write_mask, write_strobe, data_bus, output read_strobe, dq_dev_o, dq_dev_oe);
endinterface : spci_if

// File: rtl/spci_pkg.sv
// shared constants and types for the pin-level memory command interface
package spci_pkg;
    // =====================================================================
    // widths
    localparam int DATA_W  = 32;                  // shared data bus width
    localparam int LANES   = 4;                   // byte lanes
    localparam int ADDR_W  = 12;                  // address pins
    localparam int BANK_W  = 3;                   // bank select pins
    localparam int COL_W   = 9;                   // column bits kept
    localparam int BANKS   = 8;                   // internal banks
    // =====================================================================
    // address field positions
    localparam int PRE_ALL_BIT  = 8;              // precharge-all on precharge
    localparam int AUTO_PRE_BIT = 8;              // auto precharge on read/write
    localparam int COL_HI_BIT   = 9;              // top column bit
    localparam int COL_LO_TOP   = 7;              // column bits 0..7
    localparam int BL_BIT       = 0;              // mode code: burst length select
    // =====================================================================
    // burst lengths
    localparam logic [3:0] BL4 = 4'h4;            // four beats
    localparam logic [3:0] BL8 = 4'h8;            // eight beats
    // =====================================================================
    // link clock divider: half period of the generated clock in sys_clk cycles
    localparam int CK_HALF = 4;
    // command codes {cs_n, ras_n, cas_n, we_n}
    typedef enum logic [3:0] {
        SPCI_CMD_LMR  = 4'h0,                     // mode_register_load
        SPCI_CMD_REF  = 4'h1,                     // refresh
        SPCI_CMD_PRE  = 4'h2,                     // precharge
        SPCI_CMD_ACT  = 4'h3,                     // activate
        SPCI_CMD_WR   = 4'h4,                     // write
        SPCI_CMD_RD   = 4'h5,                     // read
        SPCI_CMD_NOP  = 4'h7,                     // no operation
        SPCI_CMD_DESL = 4'h8                      // deselect
    } spci_cmd_e;
endpackage : spci_pkg
